//--- rtl/cep_flags_pkg.sv
package cep_flags_pkg;
  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam int ADDR_W = 32;
  localparam logic [31:0] ENABLE_ADDR = 32'hb0006030;
  localparam logic [31:0] FLAGS_ADDR = 32'hb0006034;
  localparam logic [31:0] ENABLE_RESET = 32'h00000000;
  localparam logic [31:0] FLAGS_RESET = 32'h00001000;
  localparam int NUM_EVENTS = 13;
  localparam int BUF_VACANT_BIT = 12;
  localparam int BUF_FILLED_BIT = 11;
  localparam int STATUS_DONE_BIT = 10;
  localparam int BUS_ERROR_BIT = 9;
  localparam int STALL_SENT_BIT = 8;
  localparam int NAK_SENT_BIT = 7;
  localparam int PKT_RECEIVED_BIT = 6;
  localparam int PKT_SENT_BIT = 5;
  localparam int PING_SEEN_BIT = 4;
  localparam int IN_TOKEN_BIT = 3;
  localparam int OUT_TOKEN_BIT = 2;
  localparam int SETUP_PKT_BIT = 1;
  localparam int SETUP_TOKEN_BIT = 0;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

  // Bus access phases of the slave
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;
endpackage

//--- rtl/w1c_flag.sv
`timescale 1ns/1ps
// ****************************************************************
// One sticky event flag, write one to clear, set wins over clear
// ****************************************************************
module w1c_flag (
  input wire logic clk_in,      // Controller clock
  input wire logic reset_in,    // Synchronous reset, active high
  input wire logic enable_in,   // Clock enable
  input wire logic set_in,      // Event pulse
  input wire logic clear_in,    // Software write of one
  output logic flag_out         // Sticky flag
);
  // Set beats clear so an event landing on the clear is kept
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      flag_out <= 1'b0;
    end else if (enable_in) begin
      if (set_in) begin
        flag_out <= 1'b1;
      end else if (clear_in) begin
        flag_out <= 1'b0;
      end
    end
  end
endmodule

//--- rtl/cep_event_flags.sv
`timescale 1ns/1ps
module cep_event_flags
  import cep_flags_pkg::*;
(
  input wire logic clk_in,              // Controller clock, 10 MHz
  input wire logic reset_in,            // Synchronous reset, active high
  input wire logic clk_en_in,           // Freezes all state while low
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] address_in, // Byte address
  input wire logic read_in,             // Read request
  input wire logic write_in,            // Write request
  input wire logic [31:0] writedata_in, // Write data
  input wire logic [3:0] byteenable_in, // Byte lanes
  output logic [31:0] readdata_out,     // Read data
  output logic waitrequest_out,         // Stall the master
  // Endpoint events from the link engine, one-cycle pulses except the buffer empty level
  input wire logic buf_empty_in,        // Buffer holds no data (level)
  input wire logic buf_full_in,         // Buffer became full
  input wire logic status_done_in,      // Status stage completed
  input wire logic bus_error_in,        // Transaction error
  input wire logic stall_sent_in,       // STALL answered a token
  input wire logic nak_sent_in,         // NAK answered a token
  input wire logic pkt_received_in,     // OUT data taken and ACKed
  input wire logic pkt_sent_in,         // IN data sent and ACKed
  input wire logic ping_in,             // PING token seen
  input wire logic in_token_in,         // IN token seen
  input wire logic out_token_in,        // OUT token seen
  input wire logic setup_pkt_in,        // Setup packet stored
  input wire logic setup_token_in,      // SETUP token seen
  output logic setup_overwrite_out,     // Setup arrived with flag 1 set
  output logic irq_out                  // Level interrupt request
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  bus_state_t bus_state_r;
  logic [NUM_EVENTS-1:0] enable_r;
  logic [NUM_EVENTS-1:0] event_set;
  logic [NUM_EVENTS-1:0] flags;
  logic [NUM_EVENTS-1:0] clear_req;
  logic [31:0] flags_word;
  logic [31:0] enable_word;
  logic take;
  logic wr_enable;
  logic wr_flags;

  // Decode one register address against the request
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [31:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  // Low half of write data masked by byte enables
  function automatic logic [NUM_EVENTS-1:0] lanes(input logic [31:0] d,
                                                  input logic [3:0] be);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & d[15:0];
    lanes = m[NUM_EVENTS-1:0];
  endfunction

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  // Every access waits exactly one cycle so read data comes from a
  // flop; writes take effect on the edge where waitrequest is low.
  assign waitrequest_out = (read_in || write_in) &&
                           (bus_state_r == BUS_IDLE);
  assign take = (bus_state_r == BUS_ANSWER) && (read_in || write_in);
  assign wr_enable = take && write_in && hit(address_in, ENABLE_ADDR);
  assign wr_flags = take && write_in && hit(address_in, FLAGS_ADDR);

  // Access phase tracker
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      bus_state_r <= BUS_IDLE;
    end else if (clk_en_in) begin
      case (bus_state_r)
        BUS_IDLE: begin
          if (read_in || write_in) begin
            bus_state_r <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: bus_state_r <= BUS_IDLE;
        default: bus_state_r <= BUS_IDLE;
      endcase
    end
  end

  // Read data registered in the wait cycle; unmapped reads give zero
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      readdata_out <= 32'h00000000;
    end else if (clk_en_in && bus_state_r == BUS_IDLE && read_in) begin
      if (hit(address_in, ENABLE_ADDR)) begin
        readdata_out <= enable_word;
      end else if (hit(address_in, FLAGS_ADDR)) begin
        readdata_out <= flags_word;
      end else begin
        readdata_out <= UNMAPPED_DATA;
      end
    end
  end

  // ****************************************************************
  // Enable register
  // ****************************************************************
  // Byte lanes honoured; bits above 12 are reserved and read zero
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      enable_r <= ENABLE_RESET[NUM_EVENTS-1:0];
    end else if (clk_en_in && wr_enable) begin
      for (int i = 0; i < NUM_EVENTS; i++) begin
        if (byteenable_in[i / 8]) begin
          enable_r[i] <= writedata_in[i];
        end
      end
    end
  end
  assign enable_word = {{(32-NUM_EVENTS){1'b0}}, enable_r};

  // ****************************************************************
  // Event flags
  // ****************************************************************
  assign event_set[BUF_FILLED_BIT] = buf_full_in;
  assign event_set[STATUS_DONE_BIT] = status_done_in;
  assign event_set[BUS_ERROR_BIT] = bus_error_in;
  assign event_set[STALL_SENT_BIT] = stall_sent_in;
  assign event_set[NAK_SENT_BIT] = nak_sent_in;
  assign event_set[PKT_RECEIVED_BIT] = pkt_received_in;
  assign event_set[PKT_SENT_BIT] = pkt_sent_in;
  assign event_set[PING_SEEN_BIT] = ping_in;
  assign event_set[IN_TOKEN_BIT] = in_token_in;
  assign event_set[OUT_TOKEN_BIT] = out_token_in;
  assign event_set[SETUP_PKT_BIT] = setup_pkt_in;
  assign event_set[SETUP_TOKEN_BIT] = setup_token_in;
  assign event_set[BUF_VACANT_BIT] = 1'b0;

  // A written zero leaves a flag alone; only ones clear
  assign clear_req = wr_flags ?
                     lanes(writedata_in, byteenable_in) :
                     {NUM_EVENTS{1'b0}};

  // Sticky flags 11..0, one cell each
  genvar g;
  generate
    for (g = 0; g < BUF_VACANT_BIT; g++) begin : g_flag
      w1c_flag u_flag (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .enable_in(clk_en_in),
        .set_in(event_set[g]),
        .clear_in(clear_req[g]),
        .flag_out(flags[g])
      );
    end
  endgenerate

  // Buffer empty follows the buffer itself; writes cannot touch it.
  // Reset value 1 matches an empty buffer out of reset.
  logic vacant_r;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      vacant_r <= FLAGS_RESET[BUF_VACANT_BIT];
    end else if (clk_en_in) begin
      vacant_r <= buf_empty_in;
    end
  end
  assign flags[BUF_VACANT_BIT] = vacant_r;
  assign flags_word = {{(32-NUM_EVENTS){1'b0}}, flags};

  // ****************************************************************
  // Setup overwrite warning
  // ****************************************************************
  // The setup buffer is not guarded: a packet stored while flag 1 is
  // still set replaces the old bytes. Flag it so the fault is visible.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      setup_overwrite_out <= 1'b0;
    end else if (clk_en_in) begin
      setup_overwrite_out <= setup_pkt_in && flags[SETUP_PKT_BIT];
    end
  end

  // ****************************************************************
  // Interrupt
  // ****************************************************************
  // Masked flags still record; only the request is gated
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else if (clk_en_in) begin
      irq_out <= |(flags & enable_r);
    end
  end

endmodule

//--- tb/cep_flags_asserts.sv
`timescale 1ns/1ps
// ****************************************
// Port checks for the endpoint event flags
// ****************************************
module cep_flags_asserts
  import cep_flags_pkg::*;
(
  input wire logic clk_in, // Clock
  input wire logic reset_in, // Reset
  input wire logic [ADDR_W-1:0] address_in, // Address
  input wire logic read_in, // Read
  input wire logic write_in, // Write
  input wire logic [31:0] readdata_out, // Data
  input wire logic waitrequest_out, // Stall
  input wire logic buf_empty_in, // Empty
  input wire logic setup_pkt_in, // Setup
  input wire logic setup_overwrite_out, // Overrun
  input wire logic irq_out // Interrupt
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Bus answers after exactly one wait cycle
  wait_first_a: assert property (
    $rose(read_in || write_in) |-> waitrequest_out) else $error("No wait");
  wait_once_a: assert property (
    waitrequest_out |=> !waitrequest_out) else $error("Long wait");
  idle_wait_a: assert property (
    !(read_in || write_in) |-> !waitrequest_out) else $error("Idle wait");
  // Read data move only because of a read
  rd_hold_a: assert property (
    $changed(readdata_out) |-> $past(read_in)) else $error("Data moved");
  rd_resv_a: assert property (
    read_in && !waitrequest_out |-> readdata_out[31:13] == 19'h0)
    else $error("Reserved bits set");
  rd_unmap_a: assert property (
    read_in && !waitrequest_out && address_in != ENABLE_ADDR &&
    address_in != FLAGS_ADDR |-> readdata_out == UNMAPPED_DATA)
    else $error("Unmapped data");
  // Interrupt drops only after a write or the buffer empty level going low
  irq_fall_a: assert property (
    $fell(irq_out) |-> $past(write_in, 2) || $past(!buf_empty_in, 2) ||
    $past(!buf_empty_in))
    else $error("Interrupt fell");
  ovr_cause_a: assert property (
    setup_overwrite_out |-> $past(setup_pkt_in)) else $error("Overrun");
  cover property ($rose(irq_out));
  cover property (setup_overwrite_out);
  cover property (read_in && !waitrequest_out && address_in == FLAGS_ADDR);
endmodule
bind cep_event_flags cep_flags_asserts chk (.*);

//--- tb/usb_link_model.sv
`timescale 1ns/1ps
// ****************************************
// Link side: token and handshake events
// ****************************************
module usb_link_model (
  input wire logic clk_in, // Clock
  input wire logic [3:0] kind_in, // Event number
  input wire logic go_in, // Raise one event
  input wire logic vacant_in, // Buffer empty level
  output logic [12:0] ev_out // Event lines
);
  // Pulses last one cycle so each request is one event, never two
  always_ff @(posedge clk_in) begin
    ev_out[11:0] <= go_in ? 12'h001 << kind_in : 12'h000;
    ev_out[12] <= vacant_in;
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  bad_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
// ****************************************
// Bench for the endpoint event flags
// ****************************************
module tb;
  import cep_flags_pkg::*;
  logic clk_in = 0, reset_in = 1, clk_en_in = 1, read_in = 0, write_in = 0;
  logic [31:0] address_in = 0, writedata_in = 0, readdata_out, rd;
  logic [3:0] byteenable_in = 4'hf, kind = 0;
  logic waitrequest_out, setup_overwrite_out, irq_out, go = 0, vac = 1;
  logic [12:0] ev;
  logic ovr_seen = 0;
  int bad_count = 0, total_checks = 0;
  // Rows: enable per event; interrupt expected when own bit is on
  logic [31:0] en_tab [12] = '{32'h1, 32'h0, 32'h4, 32'hffb, 32'h10,
    32'h0, 32'h40, 32'h1f7f, 32'h100, 32'h0, 32'h400, 32'h7ff};
  usb_link_model host (.clk_in(clk_in), .kind_in(kind), .go_in(go),
    .vacant_in(vac), .ev_out(ev));
  cep_event_flags dut (.*, .buf_empty_in(ev[12]), .buf_full_in(ev[11]),
    .status_done_in(ev[10]), .bus_error_in(ev[9]), .stall_sent_in(ev[8]),
    .nak_sent_in(ev[7]), .pkt_received_in(ev[6]), .pkt_sent_in(ev[5]),
    .ping_in(ev[4]), .in_token_in(ev[3]), .out_token_in(ev[2]),
    .setup_pkt_in(ev[1]), .setup_token_in(ev[0]));
  initial forever #50 clk_in = ~clk_in;
  always @(posedge clk_in) if (setup_overwrite_out === 1'b1) ovr_seen <= 1;
  // One bus cycle; holds until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [31:0] a, d);
    int n = 0;
    address_in <= a;
    writedata_in <= d;
    write_in <= wr;
    read_in <= !wr;
    do begin
      @(posedge clk_in);
      n++;
    end while (waitrequest_out !== 1'b0 && n < 20);
    if (n >= 20) bad_count++;
    rd = readdata_out;
    write_in <= 0;
    read_in <= 0;
    @(posedge clk_in);
  endtask
  task automatic rchk(input logic [31:0] a, e);
    bus(0, a, 0);
    `CHK(rd, e)
  endtask
  // Event lands in a flag two edges on, interrupt one more
  task automatic fire(input logic [3:0] k);
    kind <= k;
    go <= 1;
    @(posedge clk_in);
    go <= 0;
    repeat (3) @(posedge clk_in);
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #(100 * 5000);
    bad_count++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    reset_in <= 0;
    @(posedge clk_in);
    rchk(ENABLE_ADDR, ENABLE_RESET);
    rchk(FLAGS_ADDR, FLAGS_RESET);
    bus(1, FLAGS_ADDR, 32'h1000);
    rchk(FLAGS_ADDR, 32'h1000);
    bus(1, ENABLE_ADDR, 32'h1000);
    @(posedge clk_in);
    `CHK(irq_out, 1'b1)
    vac <= 0;
    repeat (4) @(posedge clk_in);
    `CHK(irq_out, 1'b0)
    for (int k = 0; k < 12; k++) begin
      bus(1, ENABLE_ADDR, en_tab[k]);
      fire(k[3:0]);
      rchk(FLAGS_ADDR, 32'h1 << k);
      `CHK(irq_out, en_tab[k][k])
      bus(1, FLAGS_ADDR, 32'h0);
      rchk(FLAGS_ADDR, 32'h1 << k);
      bus(1, FLAGS_ADDR, 32'h1 << k);
      rchk(FLAGS_ADDR, 32'h0);
      `CHK(irq_out, 1'b0)
    end
    // Second setup packet while its flag is still up
    fire(4'h1);
    `CHK(ovr_seen, 1'b0)
    fire(4'h1);
    `CHK(ovr_seen, 1'b1)
    // Clock enable low: an event pulse must not reach the flags
    clk_en_in <= 0;
    fire(4'h2);
    clk_en_in <= 1;
    rchk(FLAGS_ADDR, 32'h2);
    bus(1, ENABLE_ADDR, 32'hffffffff);
    rchk(ENABLE_ADDR, 32'h1fff);
    bus(1, ENABLE_ADDR + 32'h8, 32'h1);
    rchk(ENABLE_ADDR + 32'h8, UNMAPPED_DATA);
    reset_in <= 1;
    repeat (2) @(posedge clk_in);
    reset_in <= 0;
    @(posedge clk_in);
    rchk(ENABLE_ADDR, ENABLE_RESET);
    rchk(FLAGS_ADDR, 32'h0);
    `CHK(irq_out, 1'b0)
    close_out();
  end
endmodule
